// *** hw/seq_defines.svh ***
// Notes on behaviour
// - program address advances one per executed instruction
// - bank select bits extend the fetch address
// - only low address byte visible to software
// - jump, call, interrupt, reset load target address
// - taken skip discards prefetch, inserts dummy cycle
// - low byte write jumps within current page
// - low byte write inserts one dummy cycle
// - four-bank 32K by 16 program store
// - bank taken from bank pointer bits one:zero
// - return stack holds addresses, hidden from software
// - call and interrupt push, returns pop
// - reset empties the stack level pointer
// - full stack latches interrupt, withholds acknowledge
// - call on full stack overwrites oldest entry
// - alu result updates status flags
// - standard and extended operation classes accepted
// - table pointer separate from program address
// - fetching starts at address zero after reset
// - address change costs one extra cycle
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// ------------------------------------------
// address widths
// ------------------------------------------
`define SEQ_PAGE_W 8
`define SEQ_BANK_ADDR_W 13
`define SEQ_BANK_SEL_W 2
`define SEQ_PC_W 15
`define SEQ_FLAGS_W 4

// ------------------------------------------
// stack geometry
// ------------------------------------------
`define SEQ_STACK_DEPTH 8
`define SEQ_STACK_PTR_W 3
`define SEQ_LEVEL_W 4

// ------------------------------------------
// register byte offsets
// ------------------------------------------
`define SEQ_OFF_ADDR_LOW 12'h000
`define SEQ_OFF_BANK_PTR 12'h004
`define SEQ_OFF_FLAGS 12'h008
`define SEQ_OFF_STACK_STAT 12'h00C
`define SEQ_OFF_TABLE_PTR 12'h010

// ------------------------------------------
// reset values and field positions
// ------------------------------------------
`define SEQ_RESET_PC 15'h0000
`define SEQ_PC_ONE 15'h0001
`define SEQ_RESET_BANK 2'h0
`define SEQ_RESET_FLAGS 4'h0
`define SEQ_RESET_TABLE 15'h0000
`define SEQ_STAT_FULL_BIT 8
`define SEQ_STAT_EMPTY_BIT 9
`define SEQ_STAT_PEND_BIT 16
`define SEQ_ZERO_WORD 32'h0000_0000

`endif

// *** hw/seq_pkg.sv ***
`default_nettype none
package seq_pkg;
    // operation class reported by the execution core
    typedef enum logic [2:0] {
        OP_NEXT,
        OP_JUMP,
        OP_CALL,
        OP_RET,
        OP_INTERRUPT_RETURN,
        OP_SKIP
    } op_type;
    // fetch slot state
    typedef enum logic {
        ST_DUMMY,
        ST_RUN
    } seq_state_type;
endpackage : seq_pkg
`default_nettype wire

// *** hw/stack_if.sv ***
`include "seq_defines.svh"
`default_nettype none
interface stack_if;
    logic push; // store push_addr
    logic pop; // drop newest entry
    logic [`SEQ_PC_W-1:0] push_addr; // address to save
    logic [`SEQ_PC_W-1:0] pop_addr; // newest saved address
    logic full; // every level used
    logic empty; // no level used
    logic [`SEQ_LEVEL_W-1:0] level; // levels in use
    modport owner (output push, output pop, output push_addr,
        input pop_addr, input full, input empty, input level);
    modport store (input push, input pop, input push_addr,
        output pop_addr, output full, output empty, output level);
endinterface : stack_if
`default_nettype wire

// *** hw/return_stack.sv ***
`include "seq_defines.svh"
`default_nettype none
module return_stack (
    input wire logic clk,
    input wire logic rst_n,
    stack_if.store stk
);
    // ------------------------------------------
    // storage
    // ------------------------------------------
    logic [`SEQ_PC_W-1:0] slot_ff [`SEQ_STACK_DEPTH]; // saved addresses only
    logic [`SEQ_STACK_PTR_W-1:0] wr_ptr_ff; // next free slot, wraps
    logic [`SEQ_LEVEL_W-1:0] level_ff; // used levels
    logic [`SEQ_STACK_PTR_W-1:0] top_ptr; // newest slot

    assign top_ptr = wr_ptr_ff - `SEQ_STACK_PTR_W'(1);

    // write slot on push; overflow overwrites oldest
    always_ff @(posedge clk) begin
        if (stk.push) begin
            slot_ff[wr_ptr_ff] <= stk.push_addr;
        end
    end

    // pointer and level bookkeeping
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0; // top, empty
            level_ff <= '0;
        end else if (stk.push) begin
            wr_ptr_ff <= wr_ptr_ff + `SEQ_STACK_PTR_W'(1);
            if (level_ff != `SEQ_LEVEL_W'(`SEQ_STACK_DEPTH)) begin
                level_ff <= level_ff + `SEQ_LEVEL_W'(1); // saturates when full
            end
        end else if (stk.pop && level_ff != '0) begin
            wr_ptr_ff <= top_ptr;
            level_ff <= level_ff - `SEQ_LEVEL_W'(1);
        end
    end

    // ------------------------------------------
    // status
    // ------------------------------------------
    assign stk.pop_addr = slot_ff[top_ptr];
    assign stk.full = (level_ff == `SEQ_LEVEL_W'(`SEQ_STACK_DEPTH));
    assign stk.empty = (level_ff == '0);
    assign stk.level = level_ff;
endmodule : return_stack
`default_nettype wire

// *** hw/program_sequencer_stack.sv ***
// The placing of the registers and register access over APB were left to the implementer.
`include "seq_defines.svh"
`default_nettype none
module program_sequencer_stack (
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // execution core
    input wire logic exec_valid,
    input wire seq_pkg::op_type exec_op,
    input wire logic [`SEQ_BANK_ADDR_W-1:0] exec_target,
    input wire logic alu_valid,
    input wire logic [`SEQ_FLAGS_W-1:0] alu_flags,
    // interrupt controller
    input wire logic irq_req,
    input wire logic [`SEQ_PC_W-1:0] irq_vector,
    output logic irq_ack,
    // program memory
    output logic [`SEQ_PC_W-1:0] fetch_addr,
    output logic fetch_valid,
    output logic [`SEQ_PC_W-1:0] table_addr,
    output logic [`SEQ_FLAGS_W-1:0] status_flags
);
    // ------------------------------------------
    // state and registers
    // ------------------------------------------
    seq_pkg::seq_state_type state_ff; // fetch slot state
    seq_pkg::seq_state_type nxt_state; // next slot state
    logic [`SEQ_PC_W-1:0] pc_ff; // address being fetched
    logic [`SEQ_PC_W-1:0] nxt_pc; // next fetch address
    logic [`SEQ_BANK_SEL_W-1:0] bank_ptr_ff; // software bank pointer
    logic [`SEQ_FLAGS_W-1:0] flags_ff; // alu status flags
    logic [`SEQ_PC_W-1:0] table_ptr_ff; // table pointer, separate
    logic irq_pend_ff; // latched interrupt request
    logic irq_ack_ff; // acknowledge pulse
    logic [31:0] prdata_ff; // read data captured at setup
    logic pslverr_ff; // unmapped flag captured at setup

    // ------------------------------------------
    // bus decode
    // ------------------------------------------
    logic setup_phase; // first apb cycle
    logic access_phase; // completing apb cycle
    logic addr_hit; // mapped offset
    logic wr_low; // low byte write
    logic wr_bank; // bank pointer write
    logic wr_table; // table pointer write
    logic [31:0] rd_mux; // read value for offset

    stack_if stk ();

    // ------------------------------------------
    // return stack
    // ------------------------------------------
    return_stack u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .stk(stk)
    );

    // ------------------------------------------
    // apb phase and decode
    // ------------------------------------------
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    // offset decode
    always_comb begin
        unique case (paddr)
            `SEQ_OFF_ADDR_LOW: addr_hit = 1'b1;
            `SEQ_OFF_BANK_PTR: addr_hit = 1'b1;
            `SEQ_OFF_FLAGS: addr_hit = 1'b1;
            `SEQ_OFF_STACK_STAT: addr_hit = 1'b1;
            `SEQ_OFF_TABLE_PTR: addr_hit = 1'b1;
            default: addr_hit = 1'b0; // unmapped
        endcase
    end

    // writes take effect at the completing edge only
    assign wr_low = access_phase && pwrite && (paddr == `SEQ_OFF_ADDR_LOW);
    assign wr_bank = access_phase && pwrite && (paddr == `SEQ_OFF_BANK_PTR);
    assign wr_table = access_phase && pwrite && (paddr == `SEQ_OFF_TABLE_PTR);

    // read mux, stack contents never exposed
    always_comb begin
        rd_mux = `SEQ_ZERO_WORD;
        unique case (paddr)
            `SEQ_OFF_ADDR_LOW: begin
                rd_mux[`SEQ_PAGE_W-1:0] = pc_ff[`SEQ_PAGE_W-1:0]; // low byte only
            end
            `SEQ_OFF_BANK_PTR: begin
                rd_mux[`SEQ_BANK_SEL_W-1:0] = bank_ptr_ff;
            end
            `SEQ_OFF_FLAGS: begin
                rd_mux[`SEQ_FLAGS_W-1:0] = flags_ff;
            end
            `SEQ_OFF_STACK_STAT: begin
                // full/empty state and pending interrupt bit, no level or contents
                rd_mux[`SEQ_STAT_FULL_BIT] = stk.full;
                rd_mux[`SEQ_STAT_EMPTY_BIT] = stk.empty;
                rd_mux[`SEQ_STAT_PEND_BIT] = irq_pend_ff;
            end
            `SEQ_OFF_TABLE_PTR: begin
                rd_mux[`SEQ_PC_W-1:0] = table_ptr_ff;
            end
            default: begin
                rd_mux = `SEQ_ZERO_WORD; // unmapped reads zero
            end
        endcase
    end

    // capture read data and error in setup cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_ff <= `SEQ_ZERO_WORD;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff <= pwrite ? `SEQ_ZERO_WORD : rd_mux;
            pslverr_ff <= !addr_hit;
        end
    end

    // one wait-free access phase
    assign pready = access_phase;
    assign pslverr = access_phase && pslverr_ff;
    assign prdata = prdata_ff;

    // ------------------------------------------
    // software registers
    // ------------------------------------------
    // bank pointer, bits one:zero select bank
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bank_ptr_ff <= `SEQ_RESET_BANK;
        end else if (wr_bank) begin
            bank_ptr_ff <= pwdata[`SEQ_BANK_SEL_W-1:0];
        end
    end

    // table pointer, independent of program address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            table_ptr_ff <= `SEQ_RESET_TABLE;
        end else if (wr_table) begin
            table_ptr_ff <= pwdata[`SEQ_PC_W-1:0];
        end
    end

    assign table_addr = table_ptr_ff;

    // alu status flags follow each result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_ff <= `SEQ_RESET_FLAGS;
        end else if (alu_valid) begin
            flags_ff <= alu_flags;
        end
    end

    assign status_flags = flags_ff;

    // ------------------------------------------
    // interrupt handling
    // ------------------------------------------
    logic boundary; // executed instruction may be replaced
    logic take_irq; // interrupt taken this cycle, irq_ack pulses next cycle
    logic op_taken; // core event accepted

    assign op_taken = exec_valid && (state_ff == seq_pkg::ST_RUN) && !wr_low;
    assign boundary = op_taken && (exec_op == seq_pkg::OP_NEXT);
    // acknowledge withheld while every level is used
    assign take_irq = boundary && irq_pend_ff && !stk.full;

    // request latch; a new request wins over the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_pend_ff <= 1'b0;
        end else if (irq_req) begin
            irq_pend_ff <= 1'b1; // still latched when full
        end else if (take_irq) begin
            irq_pend_ff <= 1'b0;
        end
    end

    // acknowledge pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ack_ff <= 1'b0;
        end else begin
            irq_ack_ff <= take_irq;
        end
    end

    assign irq_ack = irq_ack_ff;

    // ------------------------------------------
    // stack requests
    // ------------------------------------------
    // call and interrupt push the prefetched address
    assign stk.push = take_irq || (op_taken && exec_op == seq_pkg::OP_CALL);
    assign stk.push_addr = pc_ff;
    // both return forms pop
    assign stk.pop = op_taken &&
        (exec_op == seq_pkg::OP_RET || exec_op == seq_pkg::OP_INTERRUPT_RETURN);

    // ------------------------------------------
    // next address selection
    // ------------------------------------------
    always_comb begin
        nxt_pc = pc_ff;
        nxt_state = seq_pkg::ST_RUN;
        if (wr_low) begin
            // page-local jump, upper bits kept
            nxt_pc = {pc_ff[`SEQ_PC_W-1:`SEQ_PAGE_W], pwdata[`SEQ_PAGE_W-1:0]};
            nxt_state = seq_pkg::ST_DUMMY; // prefetch slot
        end else if (state_ff == seq_pkg::ST_DUMMY) begin
            // target fetched, move on
            nxt_pc = pc_ff + `SEQ_PC_ONE;
        end else if (take_irq) begin
            nxt_pc = irq_vector;
            nxt_state = seq_pkg::ST_DUMMY;
        end else if (op_taken) begin
            unique case (exec_op) // all operation classes land here
                seq_pkg::OP_NEXT: begin
                    nxt_pc = pc_ff + `SEQ_PC_ONE;
                end
                seq_pkg::OP_JUMP, seq_pkg::OP_CALL: begin
                    nxt_pc = {bank_ptr_ff, exec_target}; // bank-extended
                    nxt_state = seq_pkg::ST_DUMMY;
                end
                seq_pkg::OP_RET, seq_pkg::OP_INTERRUPT_RETURN: begin
                    nxt_pc = stk.pop_addr;
                    nxt_state = seq_pkg::ST_DUMMY;
                end
                seq_pkg::OP_SKIP: begin
                    // prefetched word discarded
                    nxt_pc = pc_ff + `SEQ_PC_ONE;
                    nxt_state = seq_pkg::ST_DUMMY;
                end
                default: begin
                    nxt_pc = pc_ff + `SEQ_PC_ONE; // illegal code runs on
                end
            endcase
        end else begin
            // core stalled, hold fetch
            nxt_pc = pc_ff;
        end
    end

    // ------------------------------------------
    // program address and slot state
    // ------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_ff <= `SEQ_RESET_PC;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // reset starts in a dummy slot fetching zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= seq_pkg::ST_DUMMY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------
    // fetch outputs
    // ------------------------------------------
    assign fetch_addr = pc_ff;
    // low while the slot is a dummy cycle
    assign fetch_valid = (state_ff == seq_pkg::ST_RUN);
endmodule : program_sequencer_stack
`default_nettype wire

// *** verification/core_model.sv ***
`include "seq_defines.svh"
`default_nettype none
module core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire seq_pkg::op_type op_in,
    input wire logic [12:0] tgt_in,
    input wire logic fetch_valid,
    output logic exec_valid,
    output var seq_pkg::op_type exec_op,
    output logic [12:0] exec_target,
    output logic busy
);
    // ------------------------------------------
    // one requested op, held until exec_valid presents it in a run slot
    // ------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            exec_op <= seq_pkg::OP_NEXT;
            exec_target <= 13'h0000;
        end else if (start) begin
            busy <= 1'b1;
            exec_op <= op_in; // every op class may be issued
            exec_target <= tgt_in;
        end else if (exec_valid) begin
            busy <= 1'b0;
            exec_target <= ~exec_target; // stale target scrambled
        end
    end
    // a dummy slot holds no instruction to execute
    assign exec_valid = busy && fetch_valid;
endmodule : core_model
`default_nettype wire

// *** verification/seq_props.sv ***
`include "seq_defines.svh"
`default_nettype none
module seq_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic exec_valid,
    input wire seq_pkg::op_type exec_op,
    input wire logic [12:0] exec_target,
    input wire logic alu_valid,
    input wire logic [3:0] alu_flags,
    input wire logic irq_req,
    input wire logic [14:0] irq_vector,
    input wire logic irq_ack,
    input wire logic [14:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [14:0] table_addr,
    input wire logic [3:0] status_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------
    // helpers
    // ------------------------------------------
    logic wr_low; // low address byte written this edge
    logic take; // core op accepted this edge
    assign wr_low = psel && penable && pwrite && paddr == 12'h000;
    assign take = exec_valid && fetch_valid && !wr_low;
    // one dummy slot, then the next word
    sequence dummy_run_s;
        !fetch_valid ##1 (fetch_valid && fetch_addr == $past(fetch_addr) + 15'h0001);
    endsequence
    // ------------------------------------------
    // properties
    // ------------------------------------------
    next_step_a: assert property (take && exec_op == seq_pkg::OP_NEXT |=>
        (fetch_valid && fetch_addr == $past(fetch_addr) + 15'h0001)
        || (!fetch_valid && fetch_addr == $past(irq_vector)))
        else $error("next op did not advance the address");
    hold_addr_a: assert property (fetch_valid && !take && !wr_low |=>
        fetch_addr == $past(fetch_addr)) else $error("address moved while idle");
    jump_load_a: assert property (take && exec_op == seq_pkg::OP_JUMP |=>
        fetch_addr[12:0] == $past(exec_target) ##0 dummy_run_s)
        else $error("jump target not loaded");
    branch_dummy_a: assert property (take && exec_op inside {seq_pkg::OP_JUMP,
        seq_pkg::OP_CALL, seq_pkg::OP_RET, seq_pkg::OP_INTERRUPT_RETURN, seq_pkg::OP_SKIP}
        |=> dummy_run_s) else $error("branch without one dummy slot");
    skip_step_a: assert property (take && exec_op == seq_pkg::OP_SKIP |=>
        fetch_addr == $past(fetch_addr) + 15'h0001) else $error("skip address wrong");
    low_write_a: assert property (wr_low |=>
        fetch_addr == {$past(fetch_addr[14:8]), $past(pwdata[7:0])} ##0 dummy_run_s)
        else $error("low byte write jump wrong");
    apb_answer_a: assert property (psel && penable && paddr[1:0] == 2'b00 |->
        pready && (pslverr == (paddr > 12'h010))) else $error("bus answer wrong");
    reset_start_a: assert property ($rose(rst_n) |->
        fetch_addr == 15'h0000 && !fetch_valid ##1 fetch_valid && fetch_addr == 15'h0001)
        else $error("fetch did not start at zero");
    flags_upd_a: assert property (alu_valid |=>
        status_flags == $past(alu_flags)) else $error("status flags not updated");
endmodule : seq_props
bind program_sequencer_stack seq_props u_props (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_target(exec_target), .alu_valid(alu_valid), .alu_flags(alu_flags),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .table_addr(table_addr),
    .status_flags(status_flags));
`default_nettype wire

// *** verification/test_program_sequencer_stack.sv ***
`include "seq_defines.svh"
`default_nettype none
module test_program_sequencer_stack;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------
    // signals
    // ------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, exec_valid, irq_ack, fetch_valid, busy, err;
    seq_pkg::op_type exec_op, op_in = seq_pkg::OP_NEXT;
    logic [12:0] exec_target, tgt_in = 13'h0000;
    logic start = 1'b0, alu_valid = 1'b0, irq_req = 1'b0;
    logic [3:0] alu_flags = 4'h0, status_flags;
    logic [14:0] fetch_addr, table_addr, pc_e, intp, irq_vector = 15'h4040;
    logic [14:0] saved [0:8]; // return addresses pushed by calls
    int mismatches = 0, num_checks = 0, acks = 0, a0;
    initial forever #5 clk = ~clk;
    program_sequencer_stack DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exec_valid(exec_valid), .exec_op(exec_op),
        .exec_target(exec_target), .alu_valid(alu_valid), .alu_flags(alu_flags),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .table_addr(table_addr),
        .status_flags(status_flags));
    core_model u_core (.clk(clk), .rst_n(rst_n), .start(start), .op_in(op_in),
        .tgt_in(tgt_in), .fetch_valid(fetch_valid), .exec_valid(exec_valid),
        .exec_op(exec_op), .exec_target(exec_target), .busy(busy));
    // acknowledge pulses seen
    always @(posedge clk) if (irq_ack === 1'b1) acks++;
    // ------------------------------------------
    // shared tasks
    // ------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    // one core op; e is the expected address, br marks a dummy slot
    task automatic op(input seq_pkg::op_type o, input logic [12:0] t, input logic [14:0] e,
        input logic br);
        int n;
        n = 0;
        @(posedge clk);
        start <= 1'b1;
        op_in <= o;
        tgt_in <= t;
        @(posedge clk);
        start <= 1'b0;
        #1;
        while (busy !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 20) mismatches++;
        chk(32'(fetch_addr), 32'(e));
        chk(32'(fetch_valid), 32'(!br));
        pc_e = e;
        if (br) begin
            @(posedge clk);
            #1;
            chk(32'(fetch_valid), 32'h0000_0001);
            pc_e = e + 15'h0001;
            chk(32'(fetch_addr), 32'(pc_e));
        end
    endtask : op
    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic t_reset();
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(32'(fetch_addr), 32'h0000_0000);
        chk(32'({status_flags, table_addr}), 32'h0000_0000);
        @(posedge clk);
        #1;
        pc_e = 15'h0001;
        chk(32'(fetch_addr), 32'(pc_e));
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk(rd, 32'h0000_0200);
    endtask : t_reset
    task automatic t_jump_low();
        op(seq_pkg::OP_NEXT, 13'h0000, pc_e + 15'h0001, 1'b0);
        op(seq_pkg::OP_SKIP, 13'h0000, pc_e + 15'h0001, 1'b1);
        apb(1'b1, 12'h004, 32'h0000_0003);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        op(seq_pkg::OP_JUMP, 13'h1abc, 15'h7abc, 1'b1);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_00bd);
        apb(1'b1, 12'h000, 32'h0000_0155);
        chk(32'({fetch_valid, fetch_addr}), 32'h0000_7a55);
        @(posedge clk);
        #1;
        pc_e = 15'h7a56;
        chk(32'({fetch_valid, fetch_addr}), 32'h0000_fa56);
    endtask : t_jump_low
    task automatic t_regs();
        @(posedge clk);
        alu_valid <= 1'b1;
        alu_flags <= 4'ha;
        @(posedge clk);
        alu_valid <= 1'b0;
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd, 32'h0000_000a);
        apb(1'b1, 12'h010, 32'h0000_1234);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h0000_1234);
        chk({1'b0, table_addr, 1'b0, fetch_addr}, {1'b0, 15'h1234, 1'b0, pc_e});
        apb(1'b1, 12'h014, 32'hffff_ffff);
        chk(32'(err), 32'h0000_0001);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask : t_regs
    task automatic t_stack();
        logic [12:0] t;
        apb(1'b1, 12'h004, 32'h0000_0000);
        for (int i = 0; i < 9; i++) begin
            if (i == 8) begin
                apb(1'b0, 12'h00C, 32'h0000_0000);
                chk(rd, 32'h0000_0100);
            end
            saved[i] = pc_e;
            t = 13'h0100 + 13'(i) * 13'h0010;
            op(seq_pkg::OP_CALL, t, {2'b00, t}, 1'b1);
        end
        a0 = acks;
        @(posedge clk);
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        op(seq_pkg::OP_NEXT, 13'h0000, pc_e + 15'h0001, 1'b0);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk(rd, 32'h0001_0100);
        chk(32'(acks - a0), 32'h0000_0000);
        op(seq_pkg::OP_RET, 13'h0000, saved[8], 1'b1);
        intp = pc_e;
        op(seq_pkg::OP_NEXT, 13'h0000, irq_vector, 1'b1);
        repeat (2) @(posedge clk);
        chk(32'(acks - a0), 32'h0000_0001);
        op(seq_pkg::OP_INTERRUPT_RETURN, 13'h0000, intp, 1'b1);
        for (int i = 7; i > 0; i--) op(seq_pkg::OP_RET, 13'h0000, saved[i], 1'b1);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk(rd, 32'h0000_0200);
    endtask : t_stack
    // ------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------
    initial begin
        t_reset();
        t_jump_low();
        t_regs();
        t_stack();
        results();
    end
    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule : test_program_sequencer_stack
`default_nettype wire
